// >>> rtl/cond_err_regs.svh
// Register offsets, field positions and timing constants for the condition and error status block
`ifndef COND_ERR_REGS_SVH
`define COND_ERR_REGS_SVH
`define OFS_COND 12'h000
`define OFS_LEVEL 12'h004
`define OFS_ERR 12'h008
`define OFS_ERR_CLR 12'h00C
`define OFS_CHAN 12'h010
`define CF_FLAG 0
`define CF_POS 1
`define CF_NEG 2
`define CF_ZERO 3
`define CF_CARRY 4
`define CF_HIGH 5
`define CF_LOW 6
`define CF_EQUAL 7
`define EB_STORAGE 0
`define EB_BUSPAR 1
`define EB_TMO4 2
`define EB_DFPAR 3
`define EB_PCHK 4
`define EB_TMO 5
`define EB_CHAN 6
`define EB_MAIN 7
`define CHAN_CS_BIT 6
`define RESET_BYTE 8'h00
`define MAIN_LEVEL 3'h0
`define TMO3_S 3
`define TMO_EXTRA_S 1
`define HW_TMO_MS 8
`define CLK_MHZ 100
`endif

// >>> rtl/cond_err_pkg.sv
// Types shared by the condition and error status block
package cond_err_pkg;
    typedef enum logic [1:0] {
        op_none,
        op_logic,
        op_add,
        op_sub
    } alu_op_e;
    typedef enum logic [1:0] {
        cyc_fetch,
        cyc_exec,
        cyc_steal
    } cycle_kind_e;
endpackage

// >>> rtl/loop_timeout.sv
// Looping-program watchdog: three-second stage then one further second
`timescale 1ns/100ps
`include "cond_err_regs.svh"
module loop_timeout #(
    parameter int unsigned STAGE1_CYCLES = `TMO3_S * `CLK_MHZ * 1000000,
    parameter int unsigned STAGE2_CYCLES = `TMO_EXTRA_S * `CLK_MHZ * 1000000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    input wire logic kick,
    output logic tmo3_pulse,
    output logic tmo4_pulse
);
    logic [31:0] cnt_ff;
    logic stage2_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= 32'h0000_0000;
            stage2_ff <= 1'b0;
            tmo3_pulse <= 1'b0;
            tmo4_pulse <= 1'b0;
        end else begin
            tmo3_pulse <= 1'b0;
            tmo4_pulse <= 1'b0;
            if (!enable || kick) begin
                cnt_ff <= 32'h0000_0000;
                stage2_ff <= 1'b0;
            end else if (!stage2_ff && cnt_ff == STAGE1_CYCLES - 1) begin
                cnt_ff <= 32'h0000_0000;
                stage2_ff <= 1'b1;
                tmo3_pulse <= 1'b1;
            end else if (stage2_ff && cnt_ff == STAGE2_CYCLES - 1) begin
                cnt_ff <= 32'h0000_0000;
                stage2_ff <= 1'b0;
                tmo4_pulse <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + 32'h0000_0001;
            end
        end
    end
endmodule // loop_timeout

// >>> rtl/cond_err_status.sv
// Condition flags, interrupt level backup and processor error capture with AHB-Lite access
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "cond_err_regs.svh"
//
// Contract
// - Flags change only on flag-affecting operations, showing the latest one.
// - Bit 0 is a microcode flag; hardware never changes it.
// - Bit 1 set on positive ALU result, else cleared.
// - Bit 2 set on negative ALU result, else cleared.
// - Bit 3 set on all-zero ALU result.
// - Bit 4 is carry on add, no-borrow on subtract.
// - Bit 5 set when add/subtract result positive (first higher).
// - Bit 6 set when add/subtract result negative (first lower).
// - Bit 7 set on zero result, meaning equality.
// - Level backup captures interrupt level 1-5, or empty for main level, on error.
// - Error byte captures errors in fetch, execute or cycle steal.
// - Any error set during cycle steal also sets channel error bit 6.
// - Error bit 0 on uncorrectable ECC or control storage parity.
// - Error bit 1 on bad system bus parity read.
// - Error bit 2 when loop persists one second past three-second time-out.
// - Error bit 3 on internal data flow parity error.
// - Error bit 4 on any error, four-second time-out or check halt.
// - Error bit 5 is microcode time-out, or hardware time-out with bit 6/7.
// - Error bit 6 channel check; bit 7 main processor access error.
module cond_err_status #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned STAGE1_CYCLES = `TMO3_S * `CLK_MHZ * 1000000,
    parameter int unsigned STAGE2_CYCLES = `TMO_EXTRA_S * `CLK_MHZ * 1000000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic op_valid,
    input wire cond_err_pkg::alu_op_e op_kind,
    input wire logic [WIDTH-1:0] op_a,
    input wire logic [WIDTH-1:0] op_b,
    input wire logic [WIDTH-1:0] op_result,
    input wire logic flag_set,
    input wire logic flag_clr,
    input wire cond_err_pkg::cycle_kind_e cycle_kind,
    input wire logic [2:0] level_field,
    input wire logic err_storage,
    input wire logic err_bus_parity,
    input wire logic err_data_flow,
    input wire logic err_channel,
    input wire logic err_main_access,
    input wire logic hw_tmo_channel,
    input wire logic hw_tmo_main,
    input wire logic check_halt,
    input wire logic loop_kick,
    input wire logic loop_enable,
    input wire logic err_clear,
    input wire logic [7:0] err_clear_mask,
    output logic [7:0] condition_flags_reg,
    output logic [7:0] interrupt_level_backup,
    output logic [7:0] processor_error_reg,
    output logic channel_steal_err
);
    logic tmo3;
    logic tmo4;
    logic wr_pend_ff;
    logic [11:0] wr_addr_ff;
    logic [7:0] nxt_err;
    logic [7:0] new_err;
    logic [7:0] clr_mask;
    logic [7:0] nxt_cond;
    logic sw_clr;
    logic acc;
    logic flag_op;
    logic [WIDTH:0] sum_ext;

    loop_timeout #(
        .STAGE1_CYCLES(STAGE1_CYCLES),
        .STAGE2_CYCLES(STAGE2_CYCLES)
    ) u_loop (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(loop_enable),
        .kick(loop_kick),
        .tmo3_pulse(tmo3),
        .tmo4_pulse(tmo4)
    );

    function automatic logic is_zero(input logic [WIDTH-1:0] v);
        return v == '0;
    endfunction

    // Bus access
    assign acc = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
        end else begin
            wr_pend_ff <= acc && hwrite;
            if (acc) begin
                wr_addr_ff <= haddr;
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            if (haddr == `OFS_COND) begin
                hrdata <= {24'h00_0000, nxt_cond};
            end else if (haddr == `OFS_LEVEL) begin
                hrdata <= {24'h00_0000, interrupt_level_backup};
            end else if (haddr == `OFS_ERR) begin
                hrdata <= {24'h00_0000, nxt_err};
            end else if (haddr == `OFS_CHAN) begin
                hrdata <= {31'h0000_0000, channel_steal_err} << `CHAN_CS_BIT;
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // Condition flags
    assign flag_op = op_valid && op_kind != cond_err_pkg::op_none;
    assign sum_ext = {1'b0, op_a} + {1'b0, op_b};
    always_comb begin
        nxt_cond = condition_flags_reg;
        if (wr_pend_ff && wr_addr_ff == `OFS_COND) begin
            nxt_cond[`CF_FLAG] = hwdata[`CF_FLAG];
        end
        if (flag_set) begin
            nxt_cond[`CF_FLAG] = 1'b1;
        end else if (flag_clr) begin
            nxt_cond[`CF_FLAG] = 1'b0;
        end
        if (op_valid && op_kind != cond_err_pkg::op_none) begin
            nxt_cond[`CF_POS] = !op_result[WIDTH-1] && !is_zero(op_result);
            nxt_cond[`CF_NEG] = op_result[WIDTH-1];
            nxt_cond[`CF_ZERO] = is_zero(op_result);
            nxt_cond[`CF_EQUAL] = is_zero(op_result);
            nxt_cond[`CF_CARRY] = 1'b0;
            nxt_cond[`CF_HIGH] = 1'b0;
            nxt_cond[`CF_LOW] = 1'b0;
            if (op_kind == cond_err_pkg::op_add) begin
                nxt_cond[`CF_CARRY] = sum_ext[WIDTH];
            end else if (op_kind == cond_err_pkg::op_sub) begin
                nxt_cond[`CF_CARRY] = op_a >= op_b;
            end
            if (op_kind == cond_err_pkg::op_add || op_kind == cond_err_pkg::op_sub) begin
                nxt_cond[`CF_HIGH] = !op_result[WIDTH-1] && !is_zero(op_result);
                nxt_cond[`CF_LOW] = op_result[WIDTH-1];
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            condition_flags_reg <= `RESET_BYTE;
        end else begin
            condition_flags_reg <= nxt_cond;
        end
    end

    // Error capture
    always_comb begin
        new_err = `RESET_BYTE;
        new_err[`EB_STORAGE] = err_storage;
        new_err[`EB_BUSPAR] = err_bus_parity;
        new_err[`EB_TMO4] = tmo4;
        new_err[`EB_DFPAR] = err_data_flow;
        new_err[`EB_TMO] = tmo3 || hw_tmo_channel || hw_tmo_main;
        new_err[`EB_CHAN] = err_channel || hw_tmo_channel;
        new_err[`EB_MAIN] = err_main_access || hw_tmo_main;
        new_err[`EB_PCHK] = |new_err || check_halt;
        sw_clr = wr_pend_ff && wr_addr_ff == `OFS_ERR_CLR;
        clr_mask = (sw_clr ? hwdata[7:0] : `RESET_BYTE) | (err_clear ? err_clear_mask : `RESET_BYTE);
        nxt_err = (processor_error_reg & ~clr_mask) | new_err;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            processor_error_reg <= `RESET_BYTE;
        end else begin
            processor_error_reg <= nxt_err;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interrupt_level_backup <= `RESET_BYTE;
        end else if (|new_err) begin
            interrupt_level_backup <= {5'h00, level_field};
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            channel_steal_err <= 1'b0;
        end else if (|new_err && cycle_kind == cond_err_pkg::cyc_steal) begin
            channel_steal_err <= 1'b1;
        end else if (sw_clr && hwdata[`CHAN_CS_BIT + 8]) begin
            channel_steal_err <= 1'b0;
        end
    end

    AST_ZERO_EQ: assert property (@(posedge hclk) disable iff (!hresetn)
        flag_op |=> condition_flags_reg[`CF_EQUAL] == ($past(op_result) == 0))
        else $error("equal flag wrong");
    AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        !op_valid && !flag_set && !flag_clr && !wr_pend_ff |=> $stable(condition_flags_reg))
        else $error("flags changed without operation");
    AST_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        flag_set |=> condition_flags_reg[`CF_FLAG]) else $error("flag not set");
    AST_STORAGE: assert property (@(posedge hclk) disable iff (!hresetn)
        err_storage |=> processor_error_reg[`EB_STORAGE] && processor_error_reg[`EB_PCHK])
        else $error("storage check lost");
    AST_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
        processor_error_reg[`EB_BUSPAR] && !sw_clr && !err_clear |=> processor_error_reg[`EB_BUSPAR])
        else $error("error bit dropped");
    AST_STEAL: assert property (@(posedge hclk) disable iff (!hresetn)
        err_data_flow && cycle_kind == cond_err_pkg::cyc_steal |=> channel_steal_err)
        else $error("steal error not flagged");
    AST_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
        err_bus_parity |=> interrupt_level_backup[2:0] == $past(level_field)) else $error("level not captured");
    AST_HWTMO: assert property (@(posedge hclk) disable iff (!hresetn)
        hw_tmo_main |=> processor_error_reg[`EB_TMO] && processor_error_reg[`EB_MAIN])
        else $error("hardware time-out not logged");
    AST_NEG: assert property (@(posedge hclk) disable iff (!hresetn)
        op_valid && op_kind != cond_err_pkg::op_none && !flag_set |=>
        condition_flags_reg[`CF_NEG] == $past(op_result[WIDTH-1])) else $error("negative flag wrong");

    // Condition flag checks
    AST_POS: assert property (@(posedge hclk) disable iff (!hresetn)
        flag_op |=> condition_flags_reg[`CF_POS] == ($past(op_result) != 0 && !$past(op_result[WIDTH-1])))
        else $error("positive flag wrong");

    AST_POS_NEG: assert property (@(posedge hclk) disable iff (!hresetn)
        !(condition_flags_reg[`CF_POS] && condition_flags_reg[`CF_NEG]))
        else $error("positive and negative both set");

    AST_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        flag_op |=> condition_flags_reg[`CF_ZERO] == ($past(op_result) == 0))
        else $error("zero flag wrong");

    AST_CARRY_ADD: assert property (@(posedge hclk) disable iff (!hresetn)
        op_valid && op_kind == cond_err_pkg::op_add |=> condition_flags_reg[`CF_CARRY] == ($past(op_b) > ~$past(op_a)))
        else $error("add carry wrong");

    AST_CARRY_SUB: assert property (@(posedge hclk) disable iff (!hresetn)
        op_valid && op_kind == cond_err_pkg::op_sub |=> condition_flags_reg[`CF_CARRY] == ($past(op_a) >= $past(op_b)))
        else $error("subtract carry wrong");

    AST_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
        op_valid && (op_kind == cond_err_pkg::op_add || op_kind == cond_err_pkg::op_sub) |=>
        condition_flags_reg[`CF_HIGH] == ($past(op_result) != 0 && !$past(op_result[WIDTH-1]))) else $error("high flag wrong");

    AST_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
        op_valid && (op_kind == cond_err_pkg::op_add || op_kind == cond_err_pkg::op_sub) |=>
        condition_flags_reg[`CF_LOW] == $past(op_result[WIDTH-1])) else $error("low flag wrong");

    AST_LOGIC_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
        op_valid && op_kind == cond_err_pkg::op_logic |=> !condition_flags_reg[`CF_CARRY] &&
        !condition_flags_reg[`CF_HIGH] && !condition_flags_reg[`CF_LOW]) else $error("logic op left arithmetic flags");

    AST_NONE_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        op_valid && op_kind == cond_err_pkg::op_none && !flag_set && !flag_clr && !wr_pend_ff |=>
        $stable(condition_flags_reg)) else $error("flags changed on non-flag operation");

    AST_FLAG_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
        flag_clr && !flag_set |=> !condition_flags_reg[`CF_FLAG])
        else $error("flag not cleared");

    AST_FLAG_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
        !flag_set && !flag_clr && !(wr_pend_ff && wr_addr_ff == `OFS_COND) |=>
        condition_flags_reg[`CF_FLAG] == $past(condition_flags_reg[`CF_FLAG])) else $error("flag changed by hardware");

    // Error capture checks
    AST_BUSPAR: assert property (@(posedge hclk) disable iff (!hresetn)
        err_bus_parity |=> processor_error_reg[`EB_BUSPAR] && processor_error_reg[`EB_PCHK])
        else $error("bus parity check lost");

    AST_DFPAR: assert property (@(posedge hclk) disable iff (!hresetn)
        err_data_flow |=> processor_error_reg[`EB_DFPAR] && processor_error_reg[`EB_PCHK])
        else $error("data flow parity check lost");

    AST_TMO4: assert property (@(posedge hclk) disable iff (!hresetn)
        tmo4 |=> processor_error_reg[`EB_TMO4] && processor_error_reg[`EB_PCHK])
        else $error("four-second time-out not logged");

    AST_TMO3: assert property (@(posedge hclk) disable iff (!hresetn)
        tmo3 |=> processor_error_reg[`EB_TMO])
        else $error("microcode time-out not logged");

    AST_HALT: assert property (@(posedge hclk) disable iff (!hresetn)
        check_halt |=> processor_error_reg[`EB_PCHK])
        else $error("check halt not logged");

    AST_HW_PCHK: assert property (@(posedge hclk) disable iff (!hresetn)
        hw_tmo_channel || hw_tmo_main |=> processor_error_reg[`EB_PCHK])
        else $error("hardware time-out missed processor check");

    AST_CHAN: assert property (@(posedge hclk) disable iff (!hresetn)
        err_channel |=> processor_error_reg[`EB_CHAN] && processor_error_reg[`EB_PCHK])
        else $error("channel check lost");

    AST_MAIN: assert property (@(posedge hclk) disable iff (!hresetn)
        err_main_access |=> processor_error_reg[`EB_MAIN] && processor_error_reg[`EB_PCHK])
        else $error("main processor check lost");

    AST_HWCHAN: assert property (@(posedge hclk) disable iff (!hresetn)
        hw_tmo_channel |=> processor_error_reg[`EB_TMO] && processor_error_reg[`EB_CHAN])
        else $error("channel time-out not logged");

    AST_FETCH: assert property (@(posedge hclk) disable iff (!hresetn)
        err_main_access && cycle_kind != cond_err_pkg::cyc_steal |=> processor_error_reg[`EB_MAIN])
        else $error("error outside cycle steal lost");

    AST_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        err_clear && err_clear_mask[`EB_STORAGE] && !err_storage |=> !processor_error_reg[`EB_STORAGE])
        else $error("error bit not cleared");

    AST_NO_NEW: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|new_err) && !sw_clr && !err_clear |=> $stable(processor_error_reg))
        else $error("error byte changed without cause");

    AST_LEVEL_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|new_err) |=> $stable(interrupt_level_backup))
        else $error("level backup changed without error");

    AST_STEAL_CHAN: assert property (@(posedge hclk) disable iff (!hresetn)
        err_channel && cycle_kind == cond_err_pkg::cyc_steal |=> channel_steal_err)
        else $error("steal channel error not flagged");

    AST_STEAL_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(channel_steal_err) |-> $past(cycle_kind) == cond_err_pkg::cyc_steal)
        else $error("steal flag set outside cycle steal");

    CVR_ADD: cover property (@(posedge hclk) op_valid && op_kind == cond_err_pkg::op_add);
    CVR_SUB: cover property (@(posedge hclk) op_valid && op_kind == cond_err_pkg::op_sub);
    CVR_TMO4: cover property (@(posedge hclk) tmo4);
    CVR_STEAL: cover property (@(posedge hclk) err_channel && cycle_kind == cond_err_pkg::cyc_steal);
    CVR_CLR: cover property (@(posedge hclk) sw_clr && |processor_error_reg);
endmodule // cond_err_status

// >>> testbench/tb.sv
// Self-checking bench for the condition and error status block
`timescale 1ns/100ps
`include "cond_err_regs.svh"
module tb;
    logic hclk = 0, hresetn = 0, hwrite = 0, hreadyout, hresp, cse;
    logic [1:0] htrans = 0;
    logic [11:0] haddr = 0;
    logic [31:0] hwdata = 0, hrdata, q, r, seed = 32'hef34_aec9;
    logic op_valid = 0, flag_set = 0, flag_clr = 0, loop_kick = 0, loop_enable = 0, err_clear = 0;
    cond_err_pkg::alu_op_e op_kind = cond_err_pkg::op_none;
    cond_err_pkg::cycle_kind_e cycle_kind = cond_err_pkg::cyc_fetch;
    logic [2:0] level_field = 0;
    logic [7:0] op_a = 0, op_b = 0, op_result = 0, ev = 0, clr_mask = 0, cf, lb, pe;
    logic [7:0] a, b, res, mcf, mk, mpe, em;
    logic [8:0] sum;
    logic mcs;
    logic [7:0] eset [8] = '{8'h11, 8'h12, 8'h18, 8'h50, 8'h90, 8'h70, 8'hb0, 8'h10};
    int fails = 0, n_tests = 0;
    cond_err_status #(.STAGE1_CYCLES(20), .STAGE2_CYCLES(10)) dut_u (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .op_valid(op_valid),
        .op_kind(op_kind), .op_a(op_a), .op_b(op_b), .op_result(op_result), .flag_set(flag_set),
        .flag_clr(flag_clr), .cycle_kind(cycle_kind), .level_field(level_field), .err_storage(ev[0]),
        .err_bus_parity(ev[1]), .err_data_flow(ev[2]), .err_channel(ev[3]), .err_main_access(ev[4]),
        .hw_tmo_channel(ev[5]), .hw_tmo_main(ev[6]), .check_halt(ev[7]), .loop_kick(loop_kick),
        .loop_enable(loop_enable), .err_clear(err_clear), .err_clear_mask(clr_mask),
        .condition_flags_reg(cf), .interrupt_level_backup(lb), .processor_error_reg(pe),
        .channel_steal_err(cse));
    initial begin
        forever #5 hclk = ~hclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        n_tests++;
        if ((got & m) !== (exp & m)) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got & m, exp & m);
        end
    endtask
    task ahb(input logic [11:0] ad, input logic w, input logic [31:0] d, output logic [31:0] rd);
        @(posedge hclk);
        haddr <= ad;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge hclk);
        fails++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1;
        #1 chk({cf, lb, pe, 7'h00, cse}, 0, 32'hffff_ffff);
        ahb(12'h020, 0, 0, q);
        chk(q, 0, 32'hffff_ffff);
        $display("test reset done");
        mcf = 0;
        mk = 8'hff;
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            a = r[2:1] == 2'd3 ? {1'b0, r[14:8]} : r[15:8];
            b = r[2:1] == 2'd3 ? {1'b0, r[22:16]} : r[23:16];
            sum = {1'b0, a} + {1'b0, b};
            res = r[2:1] == 2'd3 ? a - b : (r[2:1] == 2'd2 ? sum[7:0] : a ^ b);
            @(posedge hclk);
            op_valid <= r[0];
            op_kind <= cond_err_pkg::alu_op_e'(r[2:1]);
            op_a <= a;
            op_b <= b;
            op_result <= res;
            flag_set <= r[24];
            flag_clr <= r[25];
            if (r[24]) mcf[0] = 1;
            else if (r[25]) mcf[0] = 0;
            if (r[0] && r[2:1] != 2'd0) begin
                mcf[7:1] = {res == 0, $signed(res) < 0, $signed(res) > 0, r[2:1] == 2'd3 ? a >= b : sum[8],
                    res == 0, res[7], $signed(res) > 0};
                mk = r[2:1] == 2'd1 ? 8'h8f : 8'hff;
            end
            @(posedge hclk);
            op_valid <= 0;
            flag_set <= 0;
            flag_clr <= 0;
            #1 chk(cf, mcf, mk);
        end
        ahb(`OFS_COND, 1, 32'h0000_0001, q);
        ahb(`OFS_COND, 0, 0, q);
        chk(q, {mcf[7:1], 1'b1}, {24'h00_0000, mk});
        ahb(`OFS_COND, 1, 32'h0000_0000, q);
        #1 chk(cf, 0, 1);
        $display("test flags done");
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            em = 8'hff;
            @(posedge hclk);
            ev <= 8'h01 << i;
            cycle_kind <= cond_err_pkg::cycle_kind_e'(i == 2 ? 2 : r[1:0] % 3);
            level_field <= r[4:2] % 6;
            @(posedge hclk);
            ev <= 0;
            mpe = eset[i];
            mcs = i == 2 || (r[1:0] % 3) == 2;
            @(posedge hclk);
            #1 chk(pe, mpe, em);
            chk(lb, r[4:2] % 6, 8'hff);
            chk(cse, mcs, 1);
            ahb(`OFS_ERR, 0, 0, q);
            chk(q, mpe, em);
            ahb(`OFS_CHAN, 0, 0, q);
            chk(q, {25'h000_0000, mcs, 6'h00}, 32'hffff_ffff);
            ahb(`OFS_LEVEL, 0, 0, q);
            chk(q, r[4:2] % 6, 32'hffff_ffff);
            @(posedge hclk);
            err_clear <= 1;
            clr_mask <= r[15:8];
            @(posedge hclk);
            err_clear <= 0;
            mpe &= ~r[15:8];
            @(posedge hclk);
            #1 chk(pe, mpe, em);
            ahb(`OFS_ERR_CLR, 1, 32'h0000_40ff, q);
            @(posedge hclk);
            #1 chk({pe, cse}, 0, 9'h1ff);
        end
        $display("test errors done");
        @(posedge hclk);
        loop_enable <= 1;
        for (int i = 0; i < 6; i++) begin
            repeat (10) @(posedge hclk);
            loop_kick <= 1;
            @(posedge hclk);
            loop_kick <= 0;
        end
        repeat (12) @(posedge hclk);
        #1 chk(pe, 0, 8'hff);
        repeat (40) @(posedge hclk);
        #1 chk(pe, 8'h34, 8'hff);
        $display("test loop timeout done");
        conclude();
    end
endmodule // tb
